// File: hdl/block_exec.sv
// Exchange, block load and block compare execution unit with an AHB-Lite register slave.
// Assumes one synchronous byte memory: strobe in cycle k, read data valid in cycle k+1.
//
// How it works
// - Bank swap opcode swaps counter, destination, source pairs with copies; 4 states.
// - Stack-top exchange with source pair swaps bytes at SP+1 and SP; 19 states.
// - Stack-top exchange with an index register, two bytes, 23 states.
// - Block load copies source byte to destination, steps pointers, decrements counter.
// - Single block load sets parity/overflow to counter-after-decrement non-zero.
// - Block loads clear half-carry and subtract, keep carry, zero, sign.
// - Repeating incrementing load: 21 states per repeat, 16 for the last.
// - Repeating decrementing load: pointers decrement, same 21/16 state timing.
// - A repeating block load that finishes leaves parity/overflow at zero.
// - Compares set subtract, keep carry, update sign, half-carry, parity from counter.
// - Repeating compare stops on a match or when the counter reaches zero.
// - Repeating compare iteration that continues takes 21 states.
// - Terminating compare iteration, by match or zero counter, takes 16 states.
//
// Decided for this implementation: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
`include "block_exec_cfg.svh"

module block_exec (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [15:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic [7:0] mem_rdata_i,
  input wire logic int_pending_i,
  output logic busy_o,
  output block_exec_pkg::op_t active_op_o
);
  import block_exec_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] af, bc, de, hl, af_x, bc_x, de_x, hl_x, ix, iy, sp, pc;
  logic [15:0] opcode;
  st_t st;
  op_t op;
  logic dec_dir, rep;
  logic [4:0] t_cnt;
  logic [7:0] tmp_lo, tmp_hi;
  logic done, illegal;
  logic [4:0] last_t;
  logic [3:0] last_m;
  logic dp_valid, dp_write;
  logic [7:0] dp_addr;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Opcode to operation class; anything unknown is op_none
  function automatic op_t decode(input logic [15:0] code);
    op_t r;
    r = op_none;
    if (code == `OPC_BANK_SWAP) r = op_bank;
    else if (code == `OPC_EX_DE_HL) r = op_ex_dh;
    else if (code == `OPC_EX_AF) r = op_ex_af;
    else if (code == `OPC_EX_SP_HL) r = op_ex_sp_hl;
    else if (code == `OPC_EX_SP_IX) r = op_ex_sp_ix;
    else if (code == `OPC_EX_SP_IY) r = op_ex_sp_iy;
    else if (code[15:8] == `OPC_BLOCK_PREFIX) begin
      if ((code[7:0] & `OPC_BLOCK_MASK) == `OPC_BLOCK_LD) r = op_ld;
      else if ((code[7:0] & `OPC_BLOCK_MASK) == (`OPC_BLOCK_CP & `OPC_BLOCK_MASK) &&
               code[0]) r = op_cp;
    end
    return r;
  endfunction

  // Clock states for a class; repeating iterations pay five extra
  function automatic logic [4:0] t_total(input op_t o, input logic again);
    logic [4:0] r;
    r = `T_SWAP;
    unique case (o)
      op_ex_sp_hl: r = `T_EX_SP;
      op_ex_sp_ix, op_ex_sp_iy: r = `T_EX_SP_IDX;
      op_ld, op_cp: r = again ? `T_BLOCK_REP : `T_BLOCK;
      default: r = `T_SWAP;
    endcase
    return r;
  endfunction

  function automatic logic [3:0] m_total(input op_t o, input logic again);
    logic [3:0] r;
    r = `M_SWAP;
    unique case (o)
      op_ex_sp_hl: r = `M_EX_SP;
      op_ex_sp_ix, op_ex_sp_iy: r = `M_EX_SP_IDX;
      op_ld, op_cp: r = again ? `M_BLOCK_REP : `M_BLOCK;
      default: r = `M_SWAP;
    endcase
    return r;
  endfunction

  // Pointer step, up or down by one
  function automatic logic [15:0] step(input logic [15:0] v, input logic down);
    return down ? v - 16'h0001 : v + 16'h0001;
  endfunction

  // ----------------------------------------------------------------
  // Combinational helpers
  // ----------------------------------------------------------------
  logic [15:0] bc_dec, xptr;
  logic [7:0] diff;
  logic match, rep_go, fin, go_wr, wr_en, accept, start;
  op_t dec_op;

  assign bc_dec = bc - 16'h0001;
  assign diff = af[15:8] - tmp_lo;
  assign match = (af[15:8] == tmp_lo);
  assign xptr = (op == op_ex_sp_ix) ? ix : (op == op_ex_sp_iy) ? iy : hl;
  // Repeat again only with counter left and, for compares, no match
  // Only block classes repeat; the bank swap opcode has the repeat bit set too
  assign rep_go = rep && (op inside {op_ld, op_cp}) && (bc_dec != 16'h0000) &&
                  !(op == op_cp && match);
  assign fin = ce_i && (st == st_run) && (t_cnt == t_total(op, rep_go));
  assign accept = hsel_i && htrans_i[1] && hready_i;
  assign wr_en = ce_i && dp_valid && dp_write && hreadyout_o;
  assign go_wr = wr_en && (dp_addr == `OFF_CTRL) && hwdata_i[`CTRL_GO];
  assign dec_op = decode(opcode);
  assign start = go_wr && (st == st_idle);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Reads take one wait state so a write just ahead is always visible
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      hreadyout_o <= 1'b1;
      hrdata_o <= 32'h0000_0000;
      hresp_o <= 1'b0;
    end else if (ce_i) begin
      if (hreadyout_o) begin
        dp_valid <= accept;
        dp_write <= hwrite_i;
        dp_addr <= haddr_i[7:0];
        hreadyout_o <= !(accept && !hwrite_i);
      end else begin
        hreadyout_o <= 1'b1;
        unique case (dp_addr)
          `OFF_CTRL: hrdata_o <= 32'h0000_0000;
          `OFF_OPCODE: hrdata_o <= {16'h0000, opcode};
          `OFF_STATUS: hrdata_o <= {12'h000, last_m, 3'h0, last_t, 5'h00, illegal, done,
                                    (st == st_run)};
          `OFF_AF: hrdata_o <= {16'h0000, af};
          `OFF_BC: hrdata_o <= {16'h0000, bc};
          `OFF_DE: hrdata_o <= {16'h0000, de};
          `OFF_HL: hrdata_o <= {16'h0000, hl};
          `OFF_AF_X: hrdata_o <= {16'h0000, af_x};
          `OFF_BC_X: hrdata_o <= {16'h0000, bc_x};
          `OFF_DE_X: hrdata_o <= {16'h0000, de_x};
          `OFF_HL_X: hrdata_o <= {16'h0000, hl_x};
          `OFF_IX: hrdata_o <= {16'h0000, ix};
          `OFF_IY: hrdata_o <= {16'h0000, iy};
          `OFF_SP: hrdata_o <= {16'h0000, sp};
          `OFF_PC: hrdata_o <= {16'h0000, pc};
          default: hrdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: state, state counter, status
  // ----------------------------------------------------------------
  // An interrupt pending at an iteration boundary parks the unit with pc on the opcode
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= st_idle;
      t_cnt <= 5'd0;
      op <= op_none;
      dec_dir <= 1'b0;
      rep <= 1'b0;
      done <= 1'b0;
      illegal <= 1'b0;
      last_t <= 5'd0;
      last_m <= 4'd0;
    end else if (ce_i) begin
      if (start) begin
        op <= dec_op;
        dec_dir <= opcode[`OPC_BIT_DEC];
        rep <= opcode[`OPC_BIT_REP];
        done <= (dec_op == op_none);
        illegal <= (dec_op == op_none);
        st <= (dec_op == op_none) ? st_idle : st_run;
        t_cnt <= 5'd1;
      end else if (fin) begin
        last_t <= t_cnt;
        last_m <= m_total(op, rep_go);
        if (rep_go && !int_pending_i) begin
          t_cnt <= 5'd1;
        end else begin
          st <= st_idle;
          done <= 1'b1;
        end
      end else if (st == st_run) begin
        t_cnt <= t_cnt + 5'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory strobes
  // ----------------------------------------------------------------
  // Strobes last one cycle; stack exchange reads both bytes before writing either
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_addr_o <= 16'h0000;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_wdata_o <= 8'h00;
      tmp_lo <= 8'h00;
      tmp_hi <= 8'h00;
    end else if (ce_i) begin
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      if (st == st_run && !fin) begin
        unique case (op)
          op_ex_sp_hl, op_ex_sp_ix, op_ex_sp_iy: begin
            if (t_cnt == 5'd1) begin
              mem_addr_o <= sp;
              mem_rd_o <= 1'b1;
            end
            if (t_cnt == 5'd3) begin
              tmp_lo <= mem_rdata_i;
              mem_addr_o <= sp + 16'h0001;
              mem_rd_o <= 1'b1;
            end
            if (t_cnt == 5'd5) tmp_hi <= mem_rdata_i;
            if (t_cnt == 5'd6) begin
              mem_addr_o <= sp + 16'h0001;
              mem_wdata_o <= xptr[15:8];
              mem_wr_o <= 1'b1;
            end
            if (t_cnt == 5'd8) begin
              mem_addr_o <= sp;
              mem_wdata_o <= xptr[7:0];
              mem_wr_o <= 1'b1;
            end
          end
          op_ld, op_cp: begin
            if (t_cnt == 5'd1) begin
              mem_addr_o <= hl;
              mem_rd_o <= 1'b1;
            end
            if (t_cnt == 5'd3) tmp_lo <= mem_rdata_i;
            if (t_cnt == 5'd4 && op == op_ld) begin
              mem_addr_o <= de;
              mem_wdata_o <= tmp_lo;
              mem_wr_o <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file: bus writes while idle, results at the last state
  // ----------------------------------------------------------------
  // Bus writes are ignored while running so software cannot tear a pair mid-step
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      af <= `RST_WORD;
      bc <= `RST_WORD;
      de <= `RST_WORD;
      hl <= `RST_WORD;
      af_x <= `RST_WORD;
      bc_x <= `RST_WORD;
      de_x <= `RST_WORD;
      hl_x <= `RST_WORD;
      ix <= `RST_WORD;
      iy <= `RST_WORD;
      sp <= `RST_SP;
      pc <= `RST_WORD;
      opcode <= `RST_WORD;
    end else if (ce_i) begin
      if (wr_en && st == st_idle) begin
        unique case (dp_addr)
          `OFF_OPCODE: opcode <= hwdata_i[15:0];
          `OFF_AF: af <= hwdata_i[15:0];
          `OFF_BC: bc <= hwdata_i[15:0];
          `OFF_DE: de <= hwdata_i[15:0];
          `OFF_HL: hl <= hwdata_i[15:0];
          `OFF_AF_X: af_x <= hwdata_i[15:0];
          `OFF_BC_X: bc_x <= hwdata_i[15:0];
          `OFF_DE_X: de_x <= hwdata_i[15:0];
          `OFF_HL_X: hl_x <= hwdata_i[15:0];
          `OFF_IX: ix <= hwdata_i[15:0];
          `OFF_IY: iy <= hwdata_i[15:0];
          `OFF_SP: sp <= hwdata_i[15:0];
          `OFF_PC: pc <= hwdata_i[15:0];
          default: begin
          end
        endcase
      end
      if (start && dec_op != op_none) begin
        pc <= (dec_op inside {op_bank, op_ex_dh, op_ex_af, op_ex_sp_hl}) ?
              pc + 16'h0001 : pc + 16'h0002;
      end
      if (fin) begin
        unique case (op)
          op_bank: begin
            bc <= bc_x;
            de <= de_x;
            hl <= hl_x;
            bc_x <= bc;
            de_x <= de;
            hl_x <= hl;
          end
          op_ex_dh: begin
            de <= hl;
            hl <= de;
          end
          op_ex_af: begin
            af <= af_x;
            af_x <= af;
          end
          op_ex_sp_hl: hl <= {tmp_hi, tmp_lo};
          op_ex_sp_ix: ix <= {tmp_hi, tmp_lo};
          op_ex_sp_iy: iy <= {tmp_hi, tmp_lo};
          op_ld: begin
            de <= step(de, dec_dir);
            hl <= step(hl, dec_dir);
            bc <= bc_dec;
            af[`FLAG_H] <= 1'b0;
            af[`FLAG_N] <= 1'b0;
            af[`FLAG_PV] <= (bc_dec != 16'h0000);
          end
          op_cp: begin
            hl <= step(hl, dec_dir);
            bc <= bc_dec;
            af[`FLAG_Z] <= match;
            af[`FLAG_S] <= diff[7];
            af[`FLAG_H] <= (af[11:8] < tmp_lo[3:0]);
            af[`FLAG_N] <= 1'b1;
            af[`FLAG_PV] <= (bc_dec != 16'h0000);
          end
          default: begin
          end
        endcase
        // Stepping back two re-executes the same opcode next time round
        if (rep_go) pc <= pc - 16'h0002;
        if (rep_go && !int_pending_i) pc <= pc;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered side outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_o <= 1'b0;
      active_op_o <= op_none;
    end else if (ce_i) begin
      busy_o <= (start && dec_op != op_none) || (st == st_run && !(fin && !(rep_go &&
                !int_pending_i)));
      active_op_o <= start ? dec_op : op;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_bank_swap;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (fin && op == op_bank) |-> t_cnt == 5'd4 ##1 (bc == $past(bc_x) && af == $past(af));
  endproperty
  a_bank_swap: assert property (p_bank_swap) else $error("bank swap wrong");

  property p_ex_sp_time;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (fin && op == op_ex_sp_hl) |-> t_cnt == 5'd19;
  endproperty
  a_ex_sp_time: assert property (p_ex_sp_time) else $error("stack exchange length");

  property p_ex_idx_time;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (fin && op inside {op_ex_sp_ix, op_ex_sp_iy}) |-> t_cnt == 5'd23;
  endproperty
  a_ex_idx_time: assert property (p_ex_idx_time) else $error("index exchange length");

  property p_ld_copy;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (mem_wr_o && op == op_ld) |-> (mem_wdata_o == tmp_lo && mem_addr_o == de);
  endproperty
  a_ld_copy: assert property (p_ld_copy) else $error("block load copy wrong");

  property p_ld_flags;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (fin && op == op_ld) |=> (af[`FLAG_PV] == (bc != 16'h0000) && !af[`FLAG_H] &&
      !af[`FLAG_N] && af[`FLAG_C] == $past(af[`FLAG_C]) && af[`FLAG_Z] == $past(af[`FLAG_Z]));
  endproperty
  a_ld_flags: assert property (p_ld_flags) else $error("block load flags");

  property p_blk_time;
    @(posedge core_clk_i) disable iff (!resetn_i)
      fin && op inside {op_ld, op_cp} |-> t_cnt == (rep_go ? 5'd21 : 5'd16);
  endproperty
  a_blk_time: assert property (p_blk_time) else $error("block step length");

  property p_cp_flags;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (fin && op == op_cp) |=> (af[`FLAG_Z] == $past(match) && af[`FLAG_N] &&
      af[`FLAG_C] == $past(af[`FLAG_C]));
  endproperty
  a_cp_flags: assert property (p_cp_flags) else $error("compare flags");

  property p_cp_stop;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (fin && op == op_cp && rep && match) |=> (st == st_idle && done);
  endproperty
  a_cp_stop: assert property (p_cp_stop) else $error("compare kept running");

  property p_repeat_pc;
    @(posedge core_clk_i) disable iff (!resetn_i)
      (fin && rep_go && !int_pending_i) |=> (pc == $past(pc) && t_cnt == 5'd1) ##15
      (t_cnt == 5'd16);
  endproperty
  a_repeat_pc: assert property (p_repeat_pc) else $error("repeat restart wrong");

  c_block_load_inc_repeat_op_repeat: cover property (@(posedge core_clk_i) fin && op == op_ld && rep_go);
  c_block_compare_inc_repeat_op_match: cover property (@(posedge core_clk_i) fin && op == op_cp && rep && match);
  c_ex_sp_ix: cover property (@(posedge core_clk_i) fin && op == op_ex_sp_ix);
endmodule

// File: hdl/block_exec_cfg.svh
// Offsets, field positions, reset values and timing counts of the exchange/block unit.
// Assumes inclusion by its bare name from the design module and the bench.
`ifndef BLOCK_EXEC_CFG_SVH
`define BLOCK_EXEC_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets on the bus
// ----------------------------------------------------------------
`define OFF_CTRL 8'h00
`define OFF_OPCODE 8'h04
`define OFF_STATUS 8'h08
`define OFF_AF 8'h0c
`define OFF_BC 8'h10
`define OFF_DE 8'h14
`define OFF_HL 8'h18
`define OFF_AF_X 8'h1c
`define OFF_BC_X 8'h20
`define OFF_DE_X 8'h24
`define OFF_HL_X 8'h28
`define OFF_IX 8'h2c
`define OFF_IY 8'h30
`define OFF_SP 8'h34
`define OFF_PC 8'h38

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_GO 0
`define ST_BUSY 0
`define ST_DONE 1
`define ST_ILLEGAL 2
`define ST_TCNT_LSB 8
`define ST_MCNT_LSB 16
`define FLAG_S 7
`define FLAG_Z 6
`define FLAG_H 4
`define FLAG_PV 2
`define FLAG_N 1
`define FLAG_C 0

// ----------------------------------------------------------------
// Opcodes: prefix byte in [15:8], operation byte in [7:0]
// ----------------------------------------------------------------
`define OPC_BANK_SWAP 16'h00d9
`define OPC_EX_DE_HL 16'h00eb
`define OPC_EX_AF 16'h0008
`define OPC_EX_SP_HL 16'h00e3
`define OPC_EX_SP_IX 16'hdde3
`define OPC_EX_SP_IY 16'hfde3
`define OPC_BLOCK_PREFIX 8'hed
`define OPC_BLOCK_MASK 8'he7
`define OPC_BLOCK_LD 8'ha0
`define OPC_BLOCK_CP 8'ha1
`define OPC_BIT_DEC 3
`define OPC_BIT_REP 4

// ----------------------------------------------------------------
// Reset values, timing in clock states (one state per clock) and machine cycle counts
// ----------------------------------------------------------------
`define RST_WORD 16'h0000
`define RST_SP 16'hffff
`define T_SWAP 5'd4
`define T_EX_SP 5'd19
`define T_EX_SP_IDX 5'd23
`define T_BLOCK 5'd16
`define T_BLOCK_REP 5'd21
`define M_SWAP 4'd1
`define M_EX_SP 4'd5
`define M_EX_SP_IDX 4'd6
`define M_BLOCK 4'd4
`define M_BLOCK_REP 4'd5

`endif

// File: hdl/block_exec_pkg.sv
// Types shared by the exchange/block execution unit.
// Assumes the cfg header is on the include path.
package block_exec_pkg;
  // Operation classes after decode
  typedef enum logic [3:0] {
    op_none = 4'b0000,
    op_bank = 4'b0001,
    op_ex_dh = 4'b0010,
    op_ex_af = 4'b0011,
    op_ex_sp_hl = 4'b0100,
    op_ex_sp_ix = 4'b0101,
    op_ex_sp_iy = 4'b0110,
    op_ld = 4'b0111,
    op_cp = 4'b1000
  } op_t;

  // Sequencer states
  typedef enum logic {
    st_idle = 1'b0,
    st_run = 1'b1
  } st_t;
endpackage

// File: verification/byte_mem.sv
// Byte memory standing on the far side of the block unit.
// Assumes registered one-cycle strobes from the unit on core_clk_i.
`timescale 1ns/100ps
module byte_mem (
  input wire logic core_clk_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic [7:0] mem_wdata_i,
  output logic [7:0] mem_rdata_o
);
  logic [7:0] m [0:255];

  // Data valid only the cycle after a strobe; inverted otherwise so stale reads show
  always @(posedge core_clk_i) begin
    if (mem_rd_i) mem_rdata_o <= m[mem_addr_i[7:0]];
    else mem_rdata_o <= ~mem_rdata_o;
    if (mem_wr_i) m[mem_addr_i[7:0]] <= mem_wdata_i;
  end
endmodule

// File: verification/test_exchange_block_move_search_exec.sv
// Bench: random register and memory images, every opcode, compared with a model.
// Assumes the package and cfg header are compiled and on the include path.
`timescale 1ns/100ps
`include "block_exec_cfg.svh"
module test_exchange_block_move_search_exec;
  import block_exec_pkg::*;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic int_pending = 1'b0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic [15:0] mem_addr;
  logic mem_rd;
  logic mem_wr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic busy;
  op_t active_op;
  op_t cls;
  int failures = 0;
  int n_checks = 0;
  int seed = 95337;
  int waits;
  int t_exp;
  int m_exp;
  logic [15:0] r [0:11];
  logic [7:0] mm [0:255];
  logic [31:0] q;
  logic [15:0] ops [0:13] = '{`OPC_BANK_SWAP, `OPC_EX_DE_HL, `OPC_EX_AF, `OPC_EX_SP_HL,
    `OPC_EX_SP_IX, `OPC_EX_SP_IY, 16'heda0, 16'heda8, 16'hedb0, 16'hedb8, 16'heda1,
    16'heda9, 16'hedb1, 16'hedb9};

  always #2.5 core_clk_i = ~core_clk_i;

  block_exec uut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .hsel_i(1'b1),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .mem_addr_o(mem_addr), .mem_rd_o(mem_rd), .mem_wr_o(mem_wr),
    .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata), .int_pending_i(int_pending),
    .busy_o(busy), .active_op_o(active_op));

  byte_mem mem (.core_clk_i(core_clk_i), .mem_addr_i(mem_addr), .mem_rd_i(mem_rd),
    .mem_wr_i(mem_wr), .mem_wdata_i(mem_wdata), .mem_rdata_o(mem_rdata));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One clock; a wait that never ends is cut short here
  task automatic step();
    @(posedge core_clk_i);
    waits++;
    if (waits > 2000) begin
      failures++;
      wrap_up();
    end
  endtask

  // Single AHB-Lite word transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    waits = 0;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    step();
    while (hready !== 1'b1) step();
    htrans <= 2'b00;
    hwdata <= d;
    step();
    while (hready !== 1'b1) step();
    q = hrdata;
  endtask

  task automatic swap(inout logic [15:0] x, inout logic [15:0] y);
    {x, y} = {y, x};
  endtask

  // Random image; the counter is forced, and compares get a likely early match
  task automatic setup(input logic [15:0] op, input logic [15:0] bc);
    for (int i = 0; i < 256; i++) begin
      mm[i] = $random(seed);
      mem.m[i] = mm[i];
    end
    for (int i = 0; i < 12; i++) r[i] = $random(seed);
    r[1] = bc;
    if (op[0]) r[0][15:8] = mm[op[3] ? r[3][7:0] - 8'h1 : r[3][7:0] + 8'h1];
    for (int i = 0; i < 12; i++) bus(1'b1, 8'(`OFF_AF + 4 * i), {16'h0, r[i]});
  endtask

  // Behavioural reference of one instruction, including repeats
  task automatic model(input logic [15:0] op);
    int k;
    logic [7:0] b;
    logic [7:0] d;
    logic fin;
    k = op == `OPC_EX_SP_IX ? 8 : op == `OPC_EX_SP_IY ? 9 : 3;
    t_exp = 4;
    m_exp = 1;
    cls = op[15:8] == `OPC_BLOCK_PREFIX ? (op[0] ? op_cp : op_ld) :
      op[7:0] == 8'he3 ? (op[15:8] == 0 ? op_ex_sp_hl : op[13] ? op_ex_sp_iy : op_ex_sp_ix) :
      op == `OPC_EX_DE_HL ? op_ex_dh : op == `OPC_EX_AF ? op_ex_af : op_bank;
    if (op[15:8] == `OPC_BLOCK_PREFIX) begin
      fin = 1'b0;
      while (!fin) begin
        b = mm[r[3][7:0]];
        d = r[0][15:8] - b;
        if (!op[0]) mm[r[2][7:0]] = b;
        if (!op[0]) r[2] = op[3] ? r[2] - 16'h1 : r[2] + 16'h1;
        r[3] = op[3] ? r[3] - 16'h1 : r[3] + 16'h1;
        r[1] = r[1] - 16'h1;
        r[0][`FLAG_PV] = r[1] != 0;
        r[0][`FLAG_N] = op[0];
        r[0][`FLAG_H] = op[0] && r[0][11:8] < b[3:0];
        if (op[0]) r[0][`FLAG_Z] = d == 0;
        if (op[0]) r[0][`FLAG_S] = d[7];
        t_exp = (!op[4] || r[1] == 0 || (op[0] && d == 0)) ? 16 : 21;
        m_exp = t_exp == 16 ? 4 : 5;
        fin = t_exp == 16 || int_pending;
      end
      if (t_exp == 16) r[11] = r[11] + 16'h2;
    end else if (op[7:0] == 8'he3) begin
      b = mm[r[10][7:0]];
      d = mm[r[10][7:0] + 8'h1];
      mm[r[10][7:0]] = r[k][7:0];
      mm[r[10][7:0] + 8'h1] = r[k][15:8];
      r[k] = {d, b};
      t_exp = op[15:8] != 0 ? 23 : 19;
      m_exp = op[15:8] != 0 ? 6 : 5;
    end else if (op == `OPC_EX_DE_HL) swap(r[2], r[3]);
    else if (op == `OPC_EX_AF) swap(r[0], r[4]);
    else for (int i = 1; i < 4; i++) swap(r[i], r[i + 4]);
    if (op[15:8] != `OPC_BLOCK_PREFIX) r[11] = r[11] + 16'h1 + (op[15:8] != 0);
  endtask

  task automatic check_regs();
    for (int i = 0; i < 12; i++) begin
      bus(1'b0, 8'(`OFF_AF + 4 * i), 32'h0);
      check($sformatf("reg%0d", i), {16'h0, r[i]}, q);
    end
    for (int i = 0; i < 256; i++) check("memory", mm[i], mem.m[i]);
  endtask

  // Go, then, except for 4-state swaps, a write while busy that must be dropped, then poll for done
  task automatic run(input logic [15:0] op);
    bus(1'b1, `OFF_OPCODE, {16'h0, op});
    bus(1'b1, `OFF_CTRL, 32'h1);
    if (t_exp != 4) begin
      bus(1'b1, `OFF_BC, 32'h5555);
      check("busy", 32'h1, busy);
    end
    q = 32'h0;
    for (int i = 0; i < 300 && q[`ST_DONE] !== 1'b1; i++) bus(1'b0, `OFF_STATUS, 32'h0);
    if (q[`ST_DONE] !== 1'b1) begin
      failures++;
      wrap_up();
    end
    if (t_exp >= 0) begin
      check("states", t_exp, q[12:8]);
      check("mcycles", m_exp, q[19:16]);
    end
    check("active_op", cls, active_op);
    check("busy", 32'h0, busy);
    check_regs();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    @(posedge core_clk_i);
    for (int i = 0; i < 12; i++) r[i] = 16'h0;
    r[10] = `RST_SP;
    for (int i = 0; i < 256; i++) mm[i] = mem.m[i];
    check_regs();
    bus(1'b1, 8'hfc, 32'h1234);
    bus(1'b0, 8'hfc, 32'h0);
    check("unmapped", 32'h0, q);
    check("hresp", 32'h0, hresp);
    for (int p = 0; p < 2; p++) begin
      foreach (ops[j]) begin
        setup(ops[j], p ? 16'h4 : 16'h1);
        model(ops[j]);
        run(ops[j]);
      end
    end
    // An unknown opcode ends at once with done and illegal set
    bus(1'b1, `OFF_OPCODE, 32'hed00);
    bus(1'b1, `OFF_CTRL, 32'h1);
    bus(1'b0, `OFF_STATUS, 32'h0);
    check("illegal", 32'h6, q[2:0]);
    // A pending interrupt ends a repeating load after its first pass
    int_pending <= 1'b1;
    setup(16'hedb0, 16'h3);
    model(16'hedb0);
    run(16'hedb0);
    wrap_up();
  end
endmodule
